// ### verilog/owdr_top.v
// owdr_top.v: single-wire dimming receiver with pwm fallback and fault latch
// assumes all pins synchronous to pclk; control line is open drain on the board
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "owdr_defines.vh"
module owdr_top #(
	parameter [7:0]  DEV_ADDR     = 8'h5a, // arbitrary value
	parameter        EN_OFF_CYC   = `OWDR_EN_OFF_CYC,
	parameter        PWM_OFF_CYC  = `OWDR_PWM_OFF_CYC,
	parameter        DETECT_CYC   = `OWDR_DETECT_CYC,
	parameter        ACK_CYC      = `OWDR_ACK_PULSE_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        ctrl_line_in,
	output reg         ctrl_line_out,
	output reg         ctrl_line_oe,
	input  wire        pwm_in,
	input  wire        switch_node_ov_trip,
	input  wire        sink_feedback_ov_trip,
	input  wire        current_limit,
	input  wire        cycle_start,
	input  wire        supply_uvlo,
	output reg         enable_q,
	output reg         switch_on_q,
	output reg  [8:0]  sink_target_q
);
	localparam CW = 24;
	localparam [2:0] S_OFF = 3'h0, S_DETECT = 3'h1, S_WIRE = 3'h2, S_PWM = 3'h3,
		S_LATCH = 3'h4;
	localparam [1:0] A_IDLE = 2'h0, A_WAIT = 2'h1, A_PULSE = 2'h2;

	function [CW-1:0] sat_inc;
		input [CW-1:0] v;
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	reg [2:0]    mode_q;
	reg [1:0]    ack_q;
	reg          line_q, pwm_q;
	reg [CW-1:0] lo_cnt_q, hi_cnt_q, pwm_lo_q, t_q;
	reg [CW-1:0] bit_hi_q;
	reg [23:0]   shift_q;
	reg [4:0]    nbits_q;
	reg          bad_q, in_frame_q;
	reg [8:0]    bright_q;
	reg          gpio_en_q;   // software: control line driven by gpio
	reg          cmd_pref_q;  // software: allow single-wire mode
	reg          ov_latched_q, frame_ok_q;
	reg          fall_q;      // last shift settled one cycle after the edge
	wire [8:0]   duty;

	wire fall = line_q & ~ctrl_line_in;
	wire rise = ~line_q & ctrl_line_in;
	wire [23:0] word = shift_q;
	wire addr_ok = word[`OWDR_ADDR_MSB:`OWDR_ADDR_LSB] == DEV_ADDR;
	wire pwm_toggle = pwm_in ^ pwm_q;

	owdr_duty_meter #(.CW(20)) u_duty (
		.pclk   (pclk),
		.presetn(presetn),
		.pwm_in (pwm_in),
		.duty_q (duty)
	);

	////////////////////////////////////////////////////////////////////////
	// line timing and bit decode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_q <= 1'b0; pwm_q <= 1'b0;
			lo_cnt_q <= {CW{1'b0}}; hi_cnt_q <= {CW{1'b0}}; pwm_lo_q <= {CW{1'b0}};
			bit_hi_q <= {CW{1'b0}};
			shift_q <= 24'h000000; nbits_q <= 5'h00; bad_q <= 1'b0; in_frame_q <= 1'b0;
			bright_q <= `OWDR_BRIGHT_RST; frame_ok_q <= 1'b0;
		end else begin
			line_q <= ctrl_line_in;
			pwm_q  <= pwm_in;
			frame_ok_q <= 1'b0;
			pwm_lo_q <= pwm_in ? {CW{1'b0}} : sat_inc(pwm_lo_q);
			if (ack_q != A_IDLE) begin
				// host and pull-down both hold the line: last bit stays low
				lo_cnt_q <= sat_inc(lo_cnt_q);
				hi_cnt_q <= {CW{1'b0}};
			end else if (fall) begin
				bit_hi_q <= hi_cnt_q;
				lo_cnt_q <= 24'h000001;
				// first falling edge of a frame only opens a bit
				if (in_frame_q) begin
					if (lo_cnt_q >= {hi_cnt_q[22:0], 1'b0}) begin
						shift_q <= {1'b0, shift_q[23:1]};
						nbits_q <= nbits_q + 5'h01;
					end else if (hi_cnt_q >= {lo_cnt_q[22:0], 1'b0}) begin
						shift_q <= {1'b1, shift_q[23:1]};
						nbits_q <= nbits_q + 5'h01;
					end else
						bad_q <= 1'b1;
					if (nbits_q >= 5'd24)
						bad_q <= 1'b1;
				end
				in_frame_q <= (mode_q == S_WIRE) || (mode_q == S_DETECT);
			end else if (ctrl_line_in) begin
				hi_cnt_q <= rise ? 24'h000001 : sat_inc(hi_cnt_q);
				if (in_frame_q && hi_cnt_q == `OWDR_EOS_CYC) begin
					// last bit: its high time is the end-of-stream hold
					in_frame_q <= 1'b0;
					nbits_q <= 5'h00;
					bad_q <= 1'b0;
					if (!bad_q && nbits_q == 5'd23 && lo_cnt_q < `OWDR_EOS_CYC / 2) begin
						// final bit closed by end-of-stream counts as 1
						if ({1'b1, shift_q[23:17]} == DEV_ADDR) begin
							bright_q <= shift_q[9:1];
							frame_ok_q <= 1'b1;
						end
					end else if (!bad_q && nbits_q == 5'd23 && {1'b0, shift_q[23:17]} == DEV_ADDR) begin
						bright_q <= shift_q[9:1];
						frame_ok_q <= 1'b1;
					end
				end
			end else
				lo_cnt_q <= sat_inc(lo_cnt_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// acknowledge: delay then pull-down
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= A_IDLE; t_q <= {CW{1'b0}};
			ctrl_line_out <= 1'b0; ctrl_line_oe <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			ctrl_line_out <= 1'b0;
			fall_q <= fall;
			case (ack_q)
			A_IDLE: begin
				ctrl_line_oe <= 1'b0;
				// 24th falling edge with request set and address matching
				if (fall_q && in_frame_q && nbits_q == 5'd23 && !bad_q
						&& shift_q[11] && {1'b0, shift_q[23:17]} == DEV_ADDR) begin
					ack_q <= A_WAIT;
					t_q <= {CW{1'b0}};
				end
			end
			A_WAIT: begin
				t_q <= t_q + 1'b1;
				if (t_q == `OWDR_ACK_VALID_CYC - 1) begin
					ack_q <= A_PULSE;
					t_q <= {CW{1'b0}};
					ctrl_line_oe <= 1'b1;
				end
			end
			A_PULSE: begin
				t_q <= t_q + 1'b1;
				if (t_q == ACK_CYC - 1) begin
					ack_q <= A_IDLE;
					ctrl_line_oe <= 1'b0;
				end
			end
			default: ack_q <= A_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode, enable and protection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= S_OFF; enable_q <= 1'b0; switch_on_q <= 1'b0;
			sink_target_q <= 9'h000; ov_latched_q <= 1'b0;
		end else begin
			case (mode_q)
			S_OFF: begin
				enable_q <= 1'b0;
				if (ctrl_line_in && pwm_in && !supply_uvlo) begin
					mode_q <= S_DETECT;
				end
			end
			S_DETECT: begin
				// a frame during the window selects single-wire mode
				if (frame_ok_q && cmd_pref_q)
					mode_q <= S_WIRE;
				else if (hi_cnt_q >= DETECT_CYC)
					mode_q <= S_PWM;
				enable_q <= 1'b1;
			end
			S_WIRE, S_PWM: enable_q <= 1'b1;
			S_LATCH: begin
				enable_q <= 1'b0;
				if (rise || pwm_toggle)
					mode_q <= S_OFF;
			end
			default: mode_q <= S_OFF;
			endcase
			if (mode_q != S_OFF && mode_q != S_LATCH) begin
				if (supply_uvlo)
					mode_q <= S_OFF;
				else if (pwm_lo_q >= PWM_OFF_CYC)
					mode_q <= S_OFF;
				else if (gpio_en_q && lo_cnt_q >= EN_OFF_CYC && ack_q == A_IDLE)
					mode_q <= S_OFF;
				else if (switch_node_ov_trip)
					mode_q <= S_LATCH;
				else if (sink_feedback_ov_trip)
					mode_q <= S_OFF;
			end
			ov_latched_q <= mode_q == S_LATCH;
			// boost gate: off on limit until the next cycle, off on any fault
			if (!enable_q || switch_node_ov_trip || sink_feedback_ov_trip || current_limit)
				switch_on_q <= 1'b0;
			else if (cycle_start)
				switch_on_q <= 1'b1;
			if (!enable_q)
				sink_target_q <= 9'h000;
			else if (mode_q == S_WIRE)
				sink_target_q <= bright_q;
			else
				sink_target_q <= pwm_in && pwm_lo_q == 0 && duty == 9'h1ff ? 9'h1ff : duty;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
			gpio_en_q <= 1'b1; cmd_pref_q <= 1'b1;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= 32'h00000000;
				case (paddr)
				`OWDR_REG_CTRL: begin
					if (pwrite) begin
						gpio_en_q <= pwdata[0];
						cmd_pref_q <= pwdata[1];
					end
					prdata <= {30'h0, cmd_pref_q, gpio_en_q};
				end
				`OWDR_REG_STATUS: prdata <= {25'h0, ov_latched_q, ack_q != A_IDLE,
					enable_q, 1'b0, mode_q};
				`OWDR_REG_BRIGHT: prdata <= {23'h0, bright_q};
				`OWDR_REG_ADDR:   prdata <= {24'h0, DEV_ADDR};
				default:          pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule // owdr_top

// ### shared/owdr_defines.vh
// owdr_defines.vh: offsets, field positions, reset values and timing counts
// assumes a 20 MHz pclk; included by the top design file by bare name
`ifndef OWDR_DEFINES_VH
`define OWDR_DEFINES_VH

`define OWDR_CLK_MHZ          20
// times in microseconds, as printed
`define OWDR_T_START_US       2
`define OWDR_END_OF_STREAM_TIME_US         2
`define OWDR_T_ACK_VALID_US   4
`define OWDR_T_ACK_PULSE_US   512
`define OWDR_T_EN_OFF_US      2500
`define OWDR_T_PWM_OFF_US     20000
`define OWDR_T_DETECT_US      1000
// cycle counts derived from the rate
`define OWDR_EOS_CYC          (`OWDR_END_OF_STREAM_TIME_US * `OWDR_CLK_MHZ)
`define OWDR_ACK_VALID_CYC    (`OWDR_T_ACK_VALID_US * `OWDR_CLK_MHZ)
`define OWDR_ACK_PULSE_CYC    (`OWDR_T_ACK_PULSE_US * `OWDR_CLK_MHZ)
`define OWDR_EN_OFF_CYC       (`OWDR_T_EN_OFF_US * `OWDR_CLK_MHZ)
`define OWDR_PWM_OFF_CYC      (`OWDR_T_PWM_OFF_US * `OWDR_CLK_MHZ)
`define OWDR_DETECT_CYC       (`OWDR_T_DETECT_US * `OWDR_CLK_MHZ)
// command fields
`define OWDR_FRAME_BITS       24
`define OWDR_BRIGHT_MSB       8
`define OWDR_ACK_REQ_BIT      10
`define OWDR_ADDR_LSB         16
`define OWDR_ADDR_MSB         23
// apb register offsets
`define OWDR_REG_CTRL         12'h000
`define OWDR_REG_STATUS       12'h004
`define OWDR_REG_BRIGHT       12'h008
`define OWDR_REG_ADDR         12'h00c
`define OWDR_BRIGHT_RST       9'h1ff
`endif

// ### verilog/owdr_duty_meter.v
// owdr_duty_meter.v: measures pwm duty over one period as a 9-bit fraction
// assumes pwm input synchronous to pclk; output held in a register
module owdr_duty_meter #(
	parameter CW = 20
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          pwm_in,
	output reg  [8:0]    duty_q
);
	reg          pwm_q;
	reg [CW-1:0] per_q;
	reg [CW-1:0] hi_q;
	wire         rise = pwm_in & ~pwm_q;
	wire [CW+8:0] scaled = {hi_q, 9'h000} - {9'h000, hi_q};
	wire [CW+8:0] quot   = scaled / {9'h000, per_q};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_q  <= 1'b0;
			per_q  <= {CW{1'b0}};
			hi_q   <= {CW{1'b0}};
			duty_q <= 9'h1ff;
		end else begin
			pwm_q <= pwm_in;
			if (rise) begin
				// duty = 511 * high / period; combinational division every cycle is costly but small
				if (per_q != {CW{1'b0}})
					duty_q <= (quot > 511) ? 9'h1ff : quot[8:0];
				per_q <= {{(CW-1){1'b0}}, 1'b1};
				hi_q  <= {{(CW-1){1'b0}}, 1'b1};
			end else begin
				if (~&per_q)
					per_q <= per_q + 1'b1;
				if (pwm_in && ~&hi_q)
					hi_q <= hi_q + 1'b1;
				if (&per_q)
					duty_q <= pwm_in ? 9'h1ff : 9'h000;
			end
		end
	end
endmodule // owdr_duty_meter

// ### tb/owdr_top_monitor.sv
// owdr_top_monitor.sv: port-level checks on owdr_top
// assumes one pclk domain; bound into every owdr_top
module owdr_monitor #(
	parameter ACK_CYC = 50
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ctrl_line_in,
	input wire logic ctrl_line_out,
	input wire logic ctrl_line_oe,
	input wire logic pwm_in,
	input wire logic switch_node_ov_trip,
	input wire logic sink_feedback_ov_trip,
	input wire logic current_limit,
	input wire logic supply_uvlo,
	input wire logic enable_q,
	input wire logic switch_on_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int unsigned oe_cnt_q;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			oe_cnt_q <= 0;
		else
			oe_cnt_q <= ctrl_line_oe ? oe_cnt_q + 1 : 0;
	////////////////////////////////////////
	chk_apb_answer: assert property (psel && !penable |=> pready) else $error("no pready");
	chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	chk_ack_hold: assert property ($rose(ctrl_line_oe) |-> ctrl_line_oe[*8])
		else $error("ack pulse short");
	chk_ack_limit: assert property (oe_cnt_q <= ACK_CYC) else $error("ack pulse long");
	chk_line_low_only: assert property (!ctrl_line_out) else $error("line driven high");
	chk_ilim_off: assert property (current_limit |=> !switch_on_q)
		else $error("switch on in limit");
	chk_ov_off: assert property (switch_node_ov_trip || sink_feedback_ov_trip |=> !switch_on_q)
		else $error("switch on in ov");
	chk_uvlo_off: assert property (supply_uvlo |-> ##[1:2] !enable_q)
		else $error("enabled in uvlo");
	chk_ov_latch: assert property (switch_node_ov_trip ##1
		($stable(pwm_in) && $stable(ctrl_line_in))[*3] |-> !enable_q)
		else $error("ov latch lost");
	cover property ($rose(ctrl_line_oe));
	cover property ($fell(enable_q));
	cover property (pslverr);
endmodule // owdr_monitor

bind owdr_top owdr_monitor #(.ACK_CYC(ACK_CYC)) mon_u (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .ctrl_line_in, .ctrl_line_out, .ctrl_line_oe, .pwm_in,
	.switch_node_ov_trip, .sink_feedback_ov_trip, .current_limit, .supply_uvlo,
	.enable_q, .switch_on_q);

// ### tb/owdr_host_model.sv
// owdr_host_model.sv: host gpio on the control line and pwm pin
// assumes the bench resolves the open-drain line with a pull-up
module owdr_host_model (
	input  wire logic pclk,
	input  wire logic line,
	output logic      drv_low,
	output logic      pwm,
	output logic      ack_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		drv_low = 1'b0;
		pwm = 1'b0;
		ack_seen = 1'b0;
	end
	// line low while released can only be the receiver
	always @(posedge pclk)
		if (!line && !drv_low)
			ack_seen <= 1'b1;
	task automatic hold(input logic lvl, input int n);
		drv_low <= !lvl;
		repeat (n) @(posedge pclk);
	endtask
	// 10-cycle unit gives a 3:1 ratio, well inside the decision margin
	task automatic send(input logic [23:0] cmd);
		ack_seen <= 1'b0;
		hold(1'b1, 60);
		for (int i = 0; i < 24; i++) begin
			hold(1'b0, cmd[i] ? 10 : ((i == 23 && cmd[10]) ? 120 : 30));
			hold(1'b1, cmd[i] ? 30 : 10);
		end
		hold(1'b1, 60);
	endtask
endmodule // owdr_host_model

// ### tb/owdr_top_tb_top.sv
// owdr_top_tb_top.sv: directed bench for owdr_top
// assumes shortened counts; host model drives control line and pwm
module owdr_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ADR = 8'h5a; // arbitrary value
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_in, drv, ack;
	logic        ctrl_line_out, ctrl_line_oe, switch_node_ov_trip, sink_feedback_ov_trip;
	logic        current_limit, cycle_start, supply_uvlo, enable_q, switch_on_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [8:0]  sink_target_q;
	int          n_fail, tests_run, cyc_n;
	wire         ctrl_line_in = !((ctrl_line_oe && !ctrl_line_out) || drv);
	logic [23:0] cmd_t [3] = '{{ADR, 7'h02, 9'h0a5}, {ADR ^ 8'h01, 7'h02, 9'h13c},
		{ADR, 7'h00, 9'h1c3}};
	logic        ack_t [3] = '{1'b1, 1'b0, 1'b0};
	logic [31:0] brt_t [3] = '{32'h0a5, 32'h0a5, 32'h1c3};
	owdr_top #(.DEV_ADDR(ADR), .EN_OFF_CYC(200), .PWM_OFF_CYC(400), .DETECT_CYC(300),
		.ACK_CYC(50)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ctrl_line_in, .ctrl_line_out, .ctrl_line_oe, .pwm_in,
		.switch_node_ov_trip, .sink_feedback_ov_trip, .current_limit, .cycle_start,
		.supply_uvlo, .enable_q, .switch_on_q, .sink_target_q);
	owdr_host_model host_u (.pclk, .line(ctrl_line_in), .drv_low(drv), .pwm(pwm_in),
		.ack_seen(ack));
	////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= 1'b0;
		paddr <= a;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		chk(pslverr, err);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic expect_en(input logic v, input int n);
		repeat (n) if (enable_q !== v) @(posedge pclk);
		chk(enable_q, v);
	endtask
	////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// pacing pulse for the switching cycle; also bounds the run
	always @(posedge pclk) begin
		cyc_n++;
		cycle_start <= (cyc_n % 8 == 0);
		if (cyc_n == 12000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cycle_start} = '0;
		{switch_node_ov_trip, sink_feedback_ov_trip, current_limit, supply_uvlo} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(12'h000, 1'b0);
		chk(rd, 32'h3);
		apb(12'h010, 1'b1);
		repeat (50) @(posedge pclk);
		chk(enable_q, 1'b0);
		host_u.pwm <= 1'b1;
		expect_en(1'b1, 400);
		for (int i = 0; i < 3; i++) begin
			host_u.send(cmd_t[i]);
			repeat (100) @(posedge pclk);
			chk(ack, ack_t[i]);
			apb(12'h008, 1'b0);
			chk(rd, brt_t[i]);
			chk(sink_target_q, brt_t[i]);
		end
		current_limit <= 1'b1;
		@(posedge pclk);
		current_limit <= 1'b0;
		supply_uvlo <= 1'b1;
		expect_en(1'b0, 4);
		supply_uvlo <= 1'b0;
		expect_en(1'b1, 400);
		switch_node_ov_trip <= 1'b1;
		@(posedge pclk);
		switch_node_ov_trip <= 1'b0;
		expect_en(1'b0, 4);
		repeat (20) @(posedge pclk);
		apb(12'h004, 1'b0);
		chk(rd[6], 1'b1);
		chk(enable_q, 1'b0);
		host_u.pwm <= 1'b0;
		repeat (4) @(posedge pclk);
		host_u.pwm <= 1'b1;
		expect_en(1'b1, 400);
		host_u.pwm <= 1'b0;
		repeat (300) @(posedge pclk);
		chk(enable_q, 1'b1);
		expect_en(1'b0, 200);
		host_u.pwm <= 1'b1;
		expect_en(1'b1, 400);
		host_u.hold(1'b0, 150);
		chk(enable_q, 1'b1);
		expect_en(1'b0, 100);
		conclude();
	end
endmodule // owdr_top_tb_top
